// >>> design/dfmu_pkg.sv
// constants shared by the data format and move unit
package dfmu_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int BUS_W = 16;
    localparam int NUM_GPR = 8;

    // ----------------------------------------------------------------
    // operand sizes and immediate field lengths
    // ----------------------------------------------------------------
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [1:0] IL_3 = 2'h0;
    localparam logic [1:0] IL_8 = 2'h1;
    localparam logic [1:0] IL_16 = 2'h2;
    localparam logic [1:0] IL_24 = 2'h3;

    // ----------------------------------------------------------------
    // condition_flags layout, stack register and stack pointer steps
    // ----------------------------------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 3;
    localparam int FLAG_H = 5;
    localparam logic [7:0] FLAGS_RST = 8'h80;
    localparam logic [3:0] STACK_IDX = 4'h7;
    localparam logic [ADDR_W-1:0] STEP_WORD = 24'h000002;
    localparam logic [ADDR_W-1:0] STEP_LONG = 24'h000004;

    // ----------------------------------------------------------------
    // operation codes; codes below NUM_OPS are recognised
    // ----------------------------------------------------------------
    localparam logic [5:0] NUM_OPS = 6'h3E;
    localparam logic [5:0] OP_MOV_RR = 6'h00;
    localparam logic [5:0] OP_MOV_IMM = 6'h01;
    localparam logic [5:0] OP_MOV_LD = 6'h02;
    localparam logic [5:0] OP_MOV_ST = 6'h03;
    localparam logic [5:0] OP_PSYNC_LD = 6'h04;
    localparam logic [5:0] OP_PSYNC_ST = 6'h05;
    localparam logic [5:0] OP_POP = 6'h06;
    localparam logic [5:0] OP_PUSH = 6'h07;
    localparam logic [5:0] OP_ADD = 6'h08;
    localparam logic [5:0] OP_ADDX = 6'h09;
    localparam logic [5:0] OP_SUB = 6'h0A;
    localparam logic [5:0] OP_SUBX = 6'h0B;
    localparam logic [5:0] OP_DEC_ADD = 6'h0C;
    localparam logic [5:0] OP_DEC_SUB = 6'h0D;
    localparam logic [5:0] OP_SHL = 6'h0E;
    localparam logic [5:0] OP_SHR = 6'h0F;
    localparam logic [5:0] OP_ROTL = 6'h10;
    localparam logic [5:0] OP_ROTR = 6'h11;
    localparam logic [5:0] OP_CMP = 6'h12;
    localparam logic [5:0] OP_BLD = 6'h13;
    localparam logic [5:0] OP_BST = 6'h14;
    localparam logic [5:0] OP_BAND = 6'h15;
    localparam logic [5:0] OP_BOR = 6'h16;
    localparam logic [5:0] OP_BXOR = 6'h17;
    localparam logic [5:0] OP_LDC = 6'h18;
    localparam logic [5:0] OP_STC = 6'h19;
    localparam logic [5:0] OP_FETCH = 6'h1A;

    // ----------------------------------------------------------------
    // bus sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_BUS_HI = 4'b0010,
        ST_BUS_LO = 4'b0100,
        ST_FINISH = 4'b1000
    } dfmu_state_t;

endpackage

// >>> design/dfmu_alu.sv
// arithmetic, shift and decimal-adjust datapath with carry and overflow
module dfmu_alu
    import dfmu_pkg::*;
(
    input wire logic [5:0] op,
    input wire logic [1:0] size,
    input wire logic [31:0] a,
    input wire logic [31:0] b,
    input wire logic cin,
    input wire logic hin,
    output logic [31:0] result,
    output logic v_out,
    output logic c_out
);

    logic [31:0] mask;
    logic [32:0] wide;
    logic [31:0] aw;
    logic [31:0] bw;
    logic ci;
    int msb;

    always_comb
    begin
        msb = (size == SZ_BYTE) ? 7 : (size == SZ_WORD) ? 15 : 31;
        mask = (size == SZ_BYTE) ? 32'h000000FF :
               (size == SZ_WORD) ? 32'h0000FFFF : 32'hFFFFFFFF;
        aw = a & mask;
        bw = b & mask;
        ci = (op == OP_ADDX || op == OP_SUBX) ? cin : 1'b0;
        wide = 33'h0;
        result = aw;
        v_out = 1'b0;
        c_out = cin;
        case (op)
            OP_ADD, OP_ADDX:
            begin
                wide = {1'b0, aw} + {1'b0, bw} + {32'h0, ci};
                result = wide[31:0] & mask;
                c_out = wide[msb+1]; // [RULE2]
                v_out = (aw[msb] == bw[msb]) && (result[msb] != aw[msb]); // [RULE1]
            end
            OP_SUB, OP_SUBX, OP_CMP:
            begin
                wide = {1'b0, aw} - {1'b0, bw} - {32'h0, ci};
                result = wide[31:0] & mask;
                c_out = wide[msb+1]; // [RULE3]
                v_out = (aw[msb] != bw[msb]) && (result[msb] != aw[msb]); // [RULE1]
            end
            OP_SHL, OP_ROTL:
            begin
                c_out = aw[msb]; // [RULE4]
                result = ((aw << 1) | ((op == OP_ROTL) ? {31'h0, aw[msb]} : 32'h0)) & mask;
            end
            OP_SHR, OP_ROTR:
            begin
                c_out = aw[0]; // [RULE4]
                result = (aw >> 1) | (((op == OP_ROTR) ? {31'h0, aw[0]} : 32'h0) << msb);
            end
            OP_DEC_ADD:
            begin
                // two packed decimal digits in the low byte
                result = {24'h0, aw[7:0]
                    + (((aw[3:0] > 4'h9) || hin) ? 8'h06 : 8'h00)
                    + (((aw[7:0] > 8'h99) || cin) ? 8'h60 : 8'h00)}; // [RULE8]
                c_out = (aw[7:0] > 8'h99) || cin;
            end
            OP_DEC_SUB:
            begin
                result = {24'h0, aw[7:0] - (hin ? 8'h06 : 8'h00)
                    - (cin ? 8'h60 : 8'h00)}; // [RULE8]
                c_out = cin;
            end
            default:
            begin
                result = aw;
            end
        endcase
    end

endmodule

// >>> design/dfmu_core.sv
// decode and execute of moves, stack ops, flag ops and memory access
//
// Contract
// RULE1: overflow flag set on overflow, else cleared
// RULE2: carry flag bit 0, add carry out
// RULE3: subtraction reports borrow in carry flag
// RULE4: shifts and rotates load shifted-out bit
// RULE5: carry flag is the bit accumulator
// RULE6: bit, digit, byte, word, longword operands
// RULE7: bit ops pick bit 0..7 of byte
// RULE8: decimal adjust sees two packed digits
// RULE9: software aligns word and longword data evenly
// RULE10: odd word/long address forced even, no fault
// RULE11: odd fetch address forced even, no fault
// RULE12: stack accesses should be word or longword
// RULE13: sixty-two instruction codes recognised
// RULE14: byte, word and longword register views
// RULE15: move between registers, memory, immediates
// RULE16: software avoids peripheral-synchronised moves
// RULE17: pop is move then stack post-increment
// RULE18: push is pre-decrement then move
// RULE19: immediate fields of 3/8/16/24 bits
// RULE20: multi-byte data stored big-endian
module dfmu_core
    import dfmu_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [5:0] cmd_op,
    input wire logic [1:0] cmd_size,
    input wire logic [3:0] cmd_dst,
    input wire logic [3:0] cmd_src,
    input wire logic cmd_imm_sel,
    input wire logic [23:0] cmd_imm,
    input wire logic [1:0] cmd_imm_len,
    input wire logic [2:0] cmd_bit,
    input wire logic [dfmu_pkg::ADDR_W-1:0] cmd_addr,
    output logic done,
    output logic illegal,
    output logic [7:0] condition_flags,
    input wire logic [2:0] peek_idx,
    output logic [31:0] peek_data,
    output logic [15:0] fetch_word,
    output logic [dfmu_pkg::ADDR_W-1:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic mem_byte,
    output logic [dfmu_pkg::BUS_W-1:0] mem_wdata,
    input wire logic [dfmu_pkg::BUS_W-1:0] mem_rdata,
    input wire logic mem_ack
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] view_read(input logic [31:0] r, input logic [1:0] sz,
                                              input logic [3:0] idx);
        logic [31:0] v;
        v = r;
        // byte: 0-7 high halves, 8-15 low halves; word: 0-7 low, 8-15 upper
        if (sz == SZ_BYTE)
            v = idx[3] ? {24'h0, r[7:0]} : {24'h0, r[15:8]}; // [RULE14]
        else if (sz == SZ_WORD)
            v = idx[3] ? {16'h0, r[31:16]} : {16'h0, r[15:0]}; // [RULE14]
        return v;
    endfunction

    function automatic logic [31:0] view_write(input logic [31:0] r, input logic [1:0] sz,
                                               input logic [3:0] idx, input logic [31:0] d);
        logic [31:0] v;
        v = d;
        if (sz == SZ_BYTE)
            v = idx[3] ? {r[31:8], d[7:0]} : {r[31:16], d[7:0], r[7:0]}; // [RULE14]
        else if (sz == SZ_WORD)
            v = idx[3] ? {d[15:0], r[15:0]} : {r[31:16], d[15:0]};
        return v;
    endfunction

    function automatic logic [31:0] imm_decode(input logic [23:0] f, input logic [1:0] len);
        logic [31:0] v;
        case (len)
            IL_3: v = {29'h0, f[2:0]}; // [RULE19]
            IL_8: v = {24'h0, f[7:0]}; // [RULE19]
            IL_16: v = {16'h0, f[15:0]}; // [RULE19]
            default: v = {8'h0, f}; // [RULE19]
        endcase
        return v;
    endfunction

    function automatic logic [ADDR_W-1:0] align(input logic [ADDR_W-1:0] a,
                                                input logic [1:0] sz);
        // no address fault exists: for word and longword the low bit is just dropped
        return (sz == SZ_BYTE) ? a : {a[ADDR_W-1:1], 1'b0}; // [RULE10]
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    dfmu_state_t state_r;
    dfmu_state_t state_nxt;
    logic [31:0] gpr_r [0:NUM_GPR-1];
    logic [7:0] flags_r;
    logic [5:0] op_r;
    logic [1:0] size_r;
    logic [3:0] dst_r;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] sp_new_r;
    logic [31:0] data_r;
    logic done_r;
    logic illegal_r;
    logic [31:0] peek_r;
    logic [15:0] fetch_r;
    logic [15:0] wdata_r;

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    logic take;
    logic legal;
    logic is_stack;
    logic [1:0] eff_size;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] imm_val;
    logic [31:0] alu_res;
    logic alu_v;
    logic alu_c;
    logic [31:0] sp_val;
    logic [ADDR_W-1:0] step;
    logic sel_bit;
    logic [7:0] byte_val;
    logic [31:0] src_val;

    assign take = cmd_valid && (state_r == ST_IDLE);
    assign legal = cmd_op < NUM_OPS; // [RULE13]
    assign is_stack = (cmd_op == OP_PUSH) || (cmd_op == OP_POP);
    // a byte-sized stack op is widened to word to keep the stack even
    assign eff_size = (is_stack && cmd_size == SZ_BYTE) ? SZ_WORD : cmd_size;
    assign imm_val = imm_decode(cmd_imm, cmd_imm_len);
    assign opa = view_read(gpr_r[cmd_dst[2:0]], cmd_size, cmd_dst);
    assign opb = cmd_imm_sel ? imm_val : view_read(gpr_r[cmd_src[2:0]], cmd_size, cmd_src);
    assign sp_val = gpr_r[STACK_IDX[2:0]];
    assign step = (eff_size == SZ_LONG) ? STEP_LONG : STEP_WORD;
    assign byte_val = opa[7:0];
    assign sel_bit = byte_val[cmd_bit]; // [RULE7]
    assign src_val = view_read(gpr_r[cmd_src[2:0]], eff_size, cmd_src);

    dfmu_alu u_alu (
        .op(cmd_op),
        .size(cmd_size),
        .a(opa),
        .b(opb),
        .cin(flags_r[FLAG_C]),
        .hin(flags_r[FLAG_H]),
        .result(alu_res),
        .v_out(alu_v),
        .c_out(alu_c)
    );

    logic is_alu;
    logic is_load;
    logic is_store;
    assign is_alu = (cmd_op >= OP_ADD) && (cmd_op <= OP_CMP); // [RULE6]
    assign is_load = (cmd_op == OP_MOV_LD) || (cmd_op == OP_POP) || (cmd_op == OP_FETCH);
    assign is_store = (cmd_op == OP_MOV_ST) || (cmd_op == OP_PUSH);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
            begin
                if (take && legal && (is_load || is_store))
                    state_nxt = ST_BUS_HI;
            end
            ST_BUS_HI:
            begin
                if (mem_ack)
                    state_nxt = (size_r == SZ_LONG) ? ST_BUS_LO : ST_FINISH;
            end
            ST_BUS_LO:
            begin
                if (mem_ack)
                    state_nxt = ST_FINISH;
            end
            ST_FINISH:
            begin
                state_nxt = ST_IDLE;
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // ----------------------------------------------------------------
    // bus address and data; upper part at the lower address
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            op_r <= OP_MOV_RR;
            size_r <= SZ_BYTE;
            dst_r <= 4'h0;
            addr_r <= '0;
            sp_new_r <= '0;
            data_r <= 32'h0;
            wdata_r <= 16'h0;
        end
        else if (take && legal && (is_load || is_store))
        begin
            op_r <= cmd_op;
            size_r <= (cmd_op == OP_FETCH) ? SZ_WORD : eff_size;
            dst_r <= cmd_dst;
            data_r <= src_val;
            if (cmd_op == OP_PUSH)
            begin
                addr_r <= align(sp_val[ADDR_W-1:0] - step, SZ_WORD); // [RULE18]
                sp_new_r <= sp_val[ADDR_W-1:0] - step; // [RULE18]
            end
            else if (cmd_op == OP_POP)
            begin
                addr_r <= align(sp_val[ADDR_W-1:0], SZ_WORD); // [RULE17]
                sp_new_r <= sp_val[ADDR_W-1:0] + step; // [RULE17]
            end
            else if (cmd_op == OP_FETCH)
                addr_r <= align(cmd_addr, SZ_WORD); // [RULE11]
            else
                addr_r <= align(cmd_addr, cmd_size); // [RULE10]
            wdata_r <= (eff_size == SZ_LONG) ? src_val[31:16] :
                (eff_size == SZ_WORD) ? src_val[15:0] : {2{src_val[7:0]}}; // [RULE20]
        end
        else if (state_r == ST_BUS_HI && mem_ack)
        begin
            if (size_r == SZ_LONG)
            begin
                data_r[31:16] <= mem_rdata; // [RULE20]
                addr_r <= addr_r + STEP_WORD;
                wdata_r <= data_r[15:0];
            end
            else if (size_r == SZ_WORD)
                data_r <= {16'h0, mem_rdata};
            else
                data_r <= {24'h0, addr_r[0] ? mem_rdata[7:0] : mem_rdata[15:8]}; // [RULE20]
        end
        else if (state_r == ST_BUS_LO && mem_ack)
            data_r[15:0] <= mem_rdata;
    end

    assign mem_addr = addr_r;
    assign mem_wdata = wdata_r;
    assign mem_byte = size_r == SZ_BYTE;
    assign mem_rd = ((state_r == ST_BUS_HI) || (state_r == ST_BUS_LO))
        && ((op_r == OP_MOV_LD) || (op_r == OP_POP) || (op_r == OP_FETCH));
    assign mem_wr = ((state_r == ST_BUS_HI) || (state_r == ST_BUS_LO))
        && ((op_r == OP_MOV_ST) || (op_r == OP_PUSH));

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < NUM_GPR; i++)
                gpr_r[i] <= 32'h0;
        end
        else if (take && legal)
        begin
            case (cmd_op)
                OP_MOV_RR, OP_MOV_IMM:
                    gpr_r[cmd_dst[2:0]] <= view_write(gpr_r[cmd_dst[2:0]], cmd_size,
                        cmd_dst, (cmd_op == OP_MOV_IMM) ? imm_val : opb); // [RULE15]
                OP_ADD, OP_ADDX, OP_SUB, OP_SUBX, OP_SHL, OP_SHR, OP_ROTL, OP_ROTR:
                    gpr_r[cmd_dst[2:0]] <= view_write(gpr_r[cmd_dst[2:0]], cmd_size,
                        cmd_dst, alu_res);
                OP_DEC_ADD, OP_DEC_SUB:
                    gpr_r[cmd_dst[2:0]] <= view_write(gpr_r[cmd_dst[2:0]], SZ_BYTE,
                        cmd_dst, alu_res); // [RULE8]
                OP_BST:
                begin
                    // only the selected bit changes
                    gpr_r[cmd_dst[2:0]] <= view_write(gpr_r[cmd_dst[2:0]], SZ_BYTE,
                        cmd_dst, {24'h0, (byte_val & ~(8'h01 << cmd_bit))
                        | ({7'h0, flags_r[FLAG_C]} << cmd_bit)}); // [RULE7]
                end
                OP_STC:
                    gpr_r[cmd_dst[2:0]] <= view_write(gpr_r[cmd_dst[2:0]], SZ_BYTE,
                        cmd_dst, {24'h0, flags_r});
                default:
                begin
                end
            endcase
        end
        else if (state_r == ST_FINISH)
        begin
            if (op_r == OP_MOV_LD)
                gpr_r[dst_r[2:0]] <= view_write(gpr_r[dst_r[2:0]], size_r, dst_r, data_r); // [RULE15]
            else if (op_r == OP_POP)
            begin
                // a pop into the stack register ends with the incremented pointer
                if (dst_r[2:0] != STACK_IDX[2:0])
                    gpr_r[dst_r[2:0]] <= view_write(gpr_r[dst_r[2:0]], size_r, dst_r, data_r);
                gpr_r[STACK_IDX[2:0]] <= {{(32-ADDR_W){1'b0}}, sp_new_r}; // [RULE17]
            end
            else if (op_r == OP_PUSH)
                gpr_r[STACK_IDX[2:0]] <= {{(32-ADDR_W){1'b0}}, sp_new_r}; // [RULE18]
        end
    end

    // ----------------------------------------------------------------
    // condition flags
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            flags_r <= FLAGS_RST;
        else if (take && legal)
        begin
            if (is_alu)
            begin
                flags_r[FLAG_C] <= alu_c; // [RULE2]
                flags_r[FLAG_V] <= alu_v; // [RULE1]
            end
            else if (cmd_op == OP_BLD)
                flags_r[FLAG_C] <= sel_bit; // [RULE5]
            else if (cmd_op == OP_BAND)
                flags_r[FLAG_C] <= flags_r[FLAG_C] & sel_bit; // [RULE5]
            else if (cmd_op == OP_BOR)
                flags_r[FLAG_C] <= flags_r[FLAG_C] | sel_bit; // [RULE5]
            else if (cmd_op == OP_BXOR)
                flags_r[FLAG_C] <= flags_r[FLAG_C] ^ sel_bit; // [RULE5]
            else if (cmd_op == OP_LDC)
                flags_r <= imm_val[7:0];
        end
    end

    // ----------------------------------------------------------------
    // status and read-back
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            done_r <= 1'b0;
            illegal_r <= 1'b0;
            peek_r <= 32'h0;
            fetch_r <= 16'h0;
        end
        else
        begin
            // unsupported peripheral moves finish at once with no effect
            done_r <= (take && !(legal && (is_load || is_store))) || (state_r == ST_FINISH);
            illegal_r <= take && !legal; // [RULE13]
            peek_r <= gpr_r[peek_idx];
            if (state_r == ST_FINISH && op_r == OP_FETCH)
                fetch_r <= data_r[15:0]; // [RULE11]
        end
    end

    assign cmd_ready = state_r == ST_IDLE;
    assign done = done_r;
    assign illegal = illegal_r;
    assign condition_flags = flags_r;
    assign peek_data = peek_r;
    assign fetch_word = fetch_r;

endmodule

// >>> sim/dfmu_mem.sv
// memory bus model: byte array, big-endian words, optional one-cycle wait
module dfmu_mem
    import dfmu_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic slow,
    input wire logic [dfmu_pkg::ADDR_W-1:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic mem_byte,
    input wire logic [dfmu_pkg::BUS_W-1:0] mem_wdata,
    output logic [dfmu_pkg::BUS_W-1:0] mem_rdata,
    output logic mem_ack
);
    logic [7:0] m [0:255];
    logic wait_r;
    logic [7:0] a;
    assign a = {mem_addr[7:1], 1'b0};
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < 256; i++)
                m[i] <= 8'(i);
            {mem_ack, wait_r, mem_rdata} <= {2'b00, 16'hA5A5};
        end
        else if ((mem_rd || mem_wr) && !mem_ack && (wait_r || !slow))
        begin
            // upper byte sits at the even address
            {mem_ack, wait_r, mem_rdata} <= {2'b10, m[a], m[a + 8'h01]};
            if (mem_wr && mem_byte)
                m[mem_addr[7:0]] <= mem_wdata[7:0];
            else if (mem_wr)
                {m[a], m[a + 8'h01]} <= mem_wdata;
        end
        else
            // idle data toggles so a stale sample never matches
            {mem_ack, wait_r, mem_rdata} <= {1'b0, (mem_rd || mem_wr) && !mem_ack, ~mem_rdata};
    end
endmodule

// >>> sim/dfmu_core_chk.sv
// port assertions of the data format and move unit
module dfmu_core_chk
    import dfmu_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [5:0] cmd_op,
    input wire logic [23:0] cmd_imm,
    input wire logic done,
    input wire logic illegal,
    input wire logic [7:0] condition_flags,
    input wire logic [dfmu_pkg::ADDR_W-1:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic mem_byte,
    input wire logic mem_ack
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    logic take, req, memop;
    logic [7:0] imm_lo;
    assign take = cmd_valid && cmd_ready;
    assign req = mem_rd || mem_wr;
    assign memop = cmd_op inside {OP_MOV_LD, OP_MOV_ST, OP_FETCH, OP_PUSH, OP_POP};
    assign imm_lo = cmd_imm[7:0];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_odd_addr_even: assert property (req && !mem_byte |-> !mem_addr[0])
        else $error("word access on odd address");
    a_bad_code: assert property (take && cmd_op >= NUM_OPS |=> illegal && done)
        else $error("unknown code not flagged");
    a_good_code: assert property (take && cmd_op < NUM_OPS |=> !illegal)
        else $error("known code flagged");
    a_reg_done: assert property (take && !memop |=> done)
        else $error("register op not done next cycle");
    a_busy_ready: assert property (req |-> !cmd_ready)
        else $error("ready during bus access");
    a_req_hold: assert property (req && !mem_ack |=> req && $stable(mem_addr))
        else $error("bus request dropped before ack");
    a_flag_load: assert property (take && cmd_op == OP_LDC |=> condition_flags == $past(imm_lo))
        else $error("flags not loaded");
    a_one_dir: assert property (!(mem_rd && mem_wr))
        else $error("read and write together");
    c_push: cover property (take && cmd_op == OP_PUSH);
    c_read_ack: cover property (mem_rd && mem_ack);
    c_illegal: cover property (illegal);
endmodule

bind dfmu_core dfmu_core_chk u_chk (.*);

// >>> sim/tb_cpu_data_format_and_move_unit.sv
// self-checking testbench of the data format and move unit
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module tb_cpu_data_format_and_move_unit;
    timeunit 1ns;
    timeprecision 1ns;
    import dfmu_pkg::*;
    logic core_clk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, cmd_imm_sel = 1'b1, slow = 1'b0;
    logic [5:0] cmd_op = 6'h00;
    logic [1:0] cmd_size = 2'h0, cmd_imm_len = 2'h0;
    logic [3:0] cmd_dst = 4'h0, cmd_src = 4'h0;
    logic [23:0] cmd_imm = 24'h000000, cmd_addr = 24'h000000, mem_addr;
    logic [2:0] cmd_bit = 3'h0, peek_idx = 3'h0;
    logic cmd_ready, done, illegal, mem_rd, mem_wr, mem_byte, mem_ack;
    logic [7:0] condition_flags;
    logic [31:0] peek_data;
    logic [15:0] fetch_word, mem_wdata, mem_rdata;
    logic [1:0] vc;
    int mismatches = 0, total_checks = 0;
    assign vc = {condition_flags[FLAG_V], condition_flags[FLAG_C]};
    dfmu_core u_dut (.*);
    dfmu_mem u_mem (.*);
    initial
        forever #20 core_clk = ~core_clk;
    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic cmd(input logic [5:0] op, input logic [1:0] sz, input logic [3:0] r,
        input logic [23:0] im, input logic [1:0] il, input logic [23:0] ad);
        do @(negedge core_clk); while (cmd_ready !== 1'b1);
        {cmd_op, cmd_size, cmd_dst, cmd_src, cmd_imm, cmd_imm_len} = {op, sz, r, r, im, il};
        {cmd_bit, cmd_addr, cmd_valid} = {im[2:0], ad, 1'b1};
        @(negedge core_clk);
        cmd_valid = 1'b0;
        repeat (20) if (done !== 1'b1) @(negedge core_clk);
        `CHK(done, 1'b1)
    endtask
    task automatic peek(input logic [2:0] i, input logic [31:0] e);
        @(negedge core_clk);
        peek_idx = i;
        @(negedge core_clk);
        `CHK(peek_data, e)
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #(5000 * 40);
        mismatches++;
        finish_test();
    end
    initial
    begin
        repeat (5) @(negedge core_clk);
        reset_n = 1'b1;
        `CHK(condition_flags, FLAGS_RST)
        cmd(OP_LDC, SZ_BYTE, 4'h0, 24'h000001, IL_8, 24'h0);
        `CHK(condition_flags, 8'h01)
        for (int i = 0; i < 4; i++)
        begin
            cmd(OP_MOV_IMM, SZ_LONG, 4'h1, 24'hFFFFFF, 2'(i), 24'h0);
            peek(3'h1, (32'h1 << (i == 0 ? 3 : 8 * i)) - 32'h1);
        end
        cmd(OP_MOV_IMM, SZ_WORD, 4'h9, 24'h00FFFF, IL_16, 24'h0);
        peek(3'h1, 32'hFFFFFFFF);
        cmd(OP_ADD, SZ_LONG, 4'h1, 24'h000001, IL_3, 24'h0);
        `CHK(vc, 2'b01)
        cmd(OP_MOV_IMM, SZ_BYTE, 4'hA, 24'h00007F, IL_8, 24'h0);
        cmd(OP_ADD, SZ_BYTE, 4'hA, 24'h000001, IL_8, 24'h0);
        `CHK(vc, 2'b10)
        cmd(OP_SUB, SZ_BYTE, 4'hA, 24'h000081, IL_8, 24'h0);
        `CHK(vc, 2'b01)
        cmd(OP_SHL, SZ_BYTE, 4'hA, 24'h000001, IL_8, 24'h0);
        `CHK(vc, 2'b01)
        peek(3'h2, 32'h000000FE);
        cmd(OP_BLD, SZ_BYTE, 4'hA, 24'h000000, IL_3, 24'h0);
        `CHK(vc[0], 1'b0)
        cmd(OP_BLD, SZ_BYTE, 4'hA, 24'h000007, IL_3, 24'h0);
        `CHK(vc[0], 1'b1)
        cmd(OP_BST, SZ_BYTE, 4'hA, 24'h000000, IL_3, 24'h0);
        peek(3'h2, 32'h000000FF);
        cmd(OP_MOV_IMM, SZ_BYTE, 4'hA, 24'h000009, IL_8, 24'h0);
        cmd(OP_ADD, SZ_BYTE, 4'hA, 24'h000001, IL_8, 24'h0);
        cmd(OP_DEC_ADD, SZ_BYTE, 4'hA, 24'h000000, IL_8, 24'h0);
        peek(3'h2, 32'h00000010);
        // peripheral-sync moves are never issued
        for (logic [6:0] op = 7'h3D; op < 7'h40; op++)
        begin
            cmd(op[5:0], SZ_BYTE, 4'h0, 24'h0, IL_8, 24'h0);
            `CHK(illegal, op[5:0] >= NUM_OPS)
        end
        slow = 1'b1;
        cmd(OP_MOV_LD, SZ_LONG, 4'h3, 24'h0, IL_8, 24'h000021);
        peek(3'h3, 32'h20212223);
        cmd(OP_FETCH, SZ_WORD, 4'h0, 24'h0, IL_8, 24'h000031);
        `CHK(fetch_word, 16'h3031)
        slow = 1'b0;
        // even stack pointer and word size only
        cmd(OP_MOV_IMM, SZ_LONG, 4'h7, 24'h000100, IL_16, 24'h0);
        cmd(OP_MOV_IMM, SZ_WORD, 4'h2, 24'h001234, IL_16, 24'h0);
        cmd(OP_PUSH, SZ_WORD, 4'h2, 24'h0, IL_8, 24'h0);
        peek(3'h7, 32'h000000FE);
        `CHK(u_mem.m[8'hFE], 8'h12)
        cmd(OP_POP, SZ_WORD, 4'h4, 24'h0, IL_8, 24'h0);
        peek(3'h4, 32'h00001234);
        peek(3'h7, 32'h00000100);
        finish_test();
    end
endmodule
